// >>> verilog/acs_pkg.sv
// Constants, types and register map of the conversion sequencer.
package acs_pkg;

   // Register offsets on the register port.
   localparam logic [7:0] ACS_OFF_CTRL   = 8'h00;
   localparam logic [7:0] ACS_OFF_STAT   = 8'h01;
   localparam logic [7:0] ACS_OFF_RANGE  = 8'h02;
   localparam logic [7:0] ACS_OFF_XTRA   = 8'h03;
   localparam logic [7:0] ACS_OFF_RES0   = 8'h08;

   // Field positions.
   localparam int ACS_CTRL_SRC_BIT   = 0;
   localparam int ACS_CTRL_MODE_LO   = 3;
   localparam int ACS_STAT_XOOR_BIT  = 4;
   localparam int ACS_STAT_BUSY_BIT  = 5;

   // Reset values.
   localparam logic       ACS_RST_SRC  = 1'b0;
   localparam logic [1:0] ACS_RST_MODE = 2'b00;

   // Mode encodings of control bits 4:3.
   localparam logic [1:0] ACS_MODE_SIM    = 2'b00;
   localparam logic [1:0] ACS_MODE_SEQ    = 2'b01;
   localparam logic [1:0] ACS_MODE_OFFCAL = 2'b10;
   localparam logic [1:0] ACS_MODE_GAINCAL = 2'b11;

   // Timing.
   localparam int ACS_CLK_PERIOD_NS = 40;
   localparam int ACS_ADC_DIV       = 4;
   localparam int ACS_CORE_LAT_HALF = 7;
   localparam int ACS_CORE_LAT      = ACS_CORE_LAT_HALF * ACS_ADC_DIV / 2;
   localparam logic [3:0] ACS_LAST_STEP = 4'h8;

   typedef enum logic [1:0] {
      ACS_ST_IDLE = 2'b00,
      ACS_ST_SEQ  = 2'b01,
      ACS_ST_CONT = 2'b10
   } acs_state_t;

   typedef struct packed {
      logic       valid;
      logic       xtra;
      logic       last;
      logic [2:0] chan;
   } acs_tag_t;

endpackage

// >>> verilog/acs_sequencer.sv
// Conversion sequencer: start select, hold/mux control, result registers.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module acs_sequencer
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // Start sources
   input  wire logic        i_pwm_period_sync,
   input  wire logic        i_ext_start_pin,
   // Converter core result
   input  wire logic [11:0] i_core_data,
   input  wire logic        i_core_out_of_range,
   // Analog front end control
   output logic             o_adc_clk,
   output logic      [1:0]  o_mux_sel_a,
   output logic      [1:0]  o_mux_sel_b,
   output logic             o_sample_a,
   output logic             o_sample_b,
   output logic             o_core_feed,
   output logic             o_core_src_b,
   output logic             o_cal_offset,
   output logic             o_cal_gain,
   // Status
   output logic             o_seq_busy,
   output logic             o_conv_irq
);

   typedef struct packed {
      logic [1:0]                 phase;
      logic                       adc_clk;
      logic [1:0]                 ext_sync;
      logic                       ext_prev;
      logic                       pwm_prev;
      logic                       start_pend;
      acs_state_t                 state;
      logic [3:0]                 step;
      logic                       start_src;
      logic [1:0]                 mode;
      logic [1:0]                 run_mode;
      logic [3:0]                 pair_done;
      logic                       xtra_oor;
      logic [7:0]                 range_flags;
      logic [15:0]                xtra;
      logic [7:0][15:0]           result;
      logic [ACS_CORE_LAT-1:0][5:0] pipe;
      logic [1:0]                 mux_a;
      logic [1:0]                 mux_b;
      logic                       sample_a;
      logic                       sample_b;
      logic                       feed;
      logic                       src_b;
      acs_tag_t                   feed_tag;
      logic                       cal_offset;
      logic                       cal_gain;
      logic                       irq;
      logic [15:0]                rdata;
   } acs_regs_t;

   acs_regs_t r_reg;
   acs_regs_t r_next;

   // Channel fed into the core at a given step; simultaneous order is
   // 0,4,1,5,2,6,3,7 because the A hold is drained before the B hold.
   function automatic logic [2:0] acs_feed_chan(input logic       seq,
                                                input logic [3:0] step);
      logic [3:0] idx;
      idx = step - 4'h1;
      return seq ? idx[2:0] : {idx[0], idx[2:1]};
   endfunction

   function automatic logic acs_is_result(input logic [7:0] addr);
      return addr[7:3] == ACS_OFF_RES0[7:3];
   endfunction

   always_comb begin
      logic       tick;
      logic       rise;
      logic       seq_mode;
      logic [2:0] ch;
      acs_tag_t   out_tag;
      tick     = 1'b0;
      rise     = 1'b0;
      seq_mode = 1'b0;
      ch       = 3'h0;
      out_tag  = acs_tag_t'(r_reg.pipe[ACS_CORE_LAT-1]);
      r_next   = r_reg;

      // Fixed divide by four; the converter clock edge is phase 3.
      r_next.phase   = r_reg.phase + 2'h1;
      r_next.adc_clk = r_next.phase[1];
      tick           = (r_reg.phase == 2'h3);

      // Pin start: two flops, then edge detect on the second only.
      r_next.ext_sync = {r_reg.ext_sync[0], i_ext_start_pin};
      r_next.ext_prev = r_reg.ext_sync[1];
      r_next.pwm_prev = i_pwm_period_sync;
      if (r_reg.start_src) begin
         rise = r_reg.ext_sync[1] & ~r_reg.ext_prev;
      end else begin
         rise = i_pwm_period_sync & ~r_reg.pwm_prev;
      end
      // Edges during a running sequence are dropped, not queued.
      if (rise && (r_reg.state != ACS_ST_SEQ)) begin
         r_next.start_pend = 1'b1;
      end

      // Register writes; only the control register is writable.
      if (i_wr && (i_addr == ACS_OFF_CTRL)) begin
         r_next.start_src = i_wdata[ACS_CTRL_SRC_BIT];
         r_next.mode      = i_wdata[ACS_CTRL_MODE_LO+1:ACS_CTRL_MODE_LO];
      end
      r_next.cal_offset = (r_next.mode == ACS_MODE_OFFCAL);
      r_next.cal_gain   = (r_next.mode == ACS_MODE_GAINCAL);

      // Strobes last one core clock.
      r_next.sample_a = 1'b0;
      r_next.sample_b = 1'b0;
      r_next.feed     = 1'b0;
      r_next.feed_tag = '0;
      r_next.irq      = 1'b0;
      seq_mode        = (r_reg.run_mode == ACS_MODE_SEQ);

      if (tick) begin
         unique case (r_reg.state)
            ACS_ST_IDLE, ACS_ST_CONT: begin
               if (r_reg.start_pend) begin
                  // Step 0: first sample right on the next converter edge.
                  r_next.start_pend = 1'b0;
                  r_next.state      = ACS_ST_SEQ;
                  r_next.run_mode   = r_reg.mode;
                  r_next.pair_done  = 4'h0;
                  r_next.step       = 4'h1;
                  r_next.mux_a      = 2'h0;
                  r_next.mux_b      = 2'h0;
                  r_next.sample_a   = 1'b1;
                  r_next.sample_b   = (r_reg.mode != ACS_MODE_SEQ);
               end else if (r_reg.state == ACS_ST_CONT) begin
                  // Input 0 each converter clock; the first tick only primes.
                  r_next.mux_a    = 2'h0;
                  r_next.sample_a = 1'b1;
                  r_next.step     = 4'h1;
                  if (r_reg.step != 4'h0) begin
                     r_next.feed     = 1'b1;
                     r_next.src_b    = 1'b0;
                     r_next.feed_tag = '{valid: 1'b1, xtra: 1'b1,
                                         last: 1'b0, chan: 3'h0};
                  end
               end
            end
            ACS_ST_SEQ: begin
               // Feed the previously held sample into the core.
               ch              = acs_feed_chan(seq_mode, r_reg.step);
               r_next.feed     = 1'b1;
               r_next.src_b    = ch[2];
               r_next.feed_tag = '{valid: 1'b1, xtra: 1'b0,
                                   last: (r_reg.step == ACS_LAST_STEP),
                                   chan: ch};
               if (seq_mode && (r_reg.step < ACS_LAST_STEP)) begin
                  // One input per converter clock, ascending.
                  r_next.mux_a    = r_reg.step[1:0];
                  r_next.mux_b    = r_reg.step[1:0];
                  r_next.sample_a = ~r_reg.step[2];
                  r_next.sample_b = r_reg.step[2];
               end else if (!seq_mode && !r_reg.step[0] &&
                            (r_reg.step < ACS_LAST_STEP)) begin
                  // Next pair two converter clocks after the previous one.
                  r_next.mux_a    = r_reg.step[2:1];
                  r_next.mux_b    = r_reg.step[2:1];
                  r_next.sample_a = 1'b1;
                  r_next.sample_b = 1'b1;
               end
               if (r_reg.step == ACS_LAST_STEP) begin
                  r_next.state = ACS_ST_CONT;
                  r_next.step  = 4'h0;
               end else begin
                  r_next.step = r_reg.step + 4'h1;
               end
            end
            default: begin
               r_next.state = ACS_ST_IDLE;
               r_next.step  = 4'h0;
            end
         endcase
      end

      // Core latency line: the tag leaves as the core result is valid.
      r_next.pipe[0] = r_reg.feed ? 6'(r_reg.feed_tag) : 6'h00;
      for (int i = 1; i < ACS_CORE_LAT; i++) begin
         r_next.pipe[i] = r_reg.pipe[i-1];
      end

      // Capture runs after the start clear so a completing pair wins.
      if (out_tag.valid) begin
         if (out_tag.xtra) begin
            r_next.xtra     = {i_core_data, 4'h0};
            r_next.xtra_oor = i_core_out_of_range;
         end else begin
            r_next.result[out_tag.chan] = {i_core_data, 4'h0};
            r_next.range_flags[out_tag.chan] = i_core_out_of_range;
            if (out_tag.chan[2] && (r_reg.run_mode != ACS_MODE_SEQ)) begin
               r_next.pair_done[out_tag.chan[1:0]] = 1'b1;
            end
            r_next.irq = out_tag.last;
         end
      end

      // Read data stand only in the cycle after the read strobe.
      r_next.rdata = 16'h0000;
      if (i_rd) begin
         if (acs_is_result(i_addr)) begin
            r_next.rdata = r_reg.result[i_addr[2:0]];
         end else if (i_addr == ACS_OFF_CTRL) begin
            r_next.rdata[ACS_CTRL_SRC_BIT] = r_reg.start_src;
            r_next.rdata[ACS_CTRL_MODE_LO+1:ACS_CTRL_MODE_LO] = r_reg.mode;
         end else if (i_addr == ACS_OFF_STAT) begin
            r_next.rdata[3:0] = r_reg.pair_done;
            r_next.rdata[ACS_STAT_XOOR_BIT] = r_reg.xtra_oor;
            r_next.rdata[ACS_STAT_BUSY_BIT] = (r_reg.state == ACS_ST_SEQ);
         end else if (i_addr == ACS_OFF_RANGE) begin
            r_next.rdata[7:0] = r_reg.range_flags;
         end else if (i_addr == ACS_OFF_XTRA) begin
            r_next.rdata = r_reg.xtra;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         r_reg           <= '0;
         r_reg.start_src <= ACS_RST_SRC;
         r_reg.mode      <= ACS_RST_MODE;
         r_reg.run_mode  <= ACS_RST_MODE;
         r_reg.state     <= ACS_ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_rdata      = r_reg.rdata;
   assign o_adc_clk    = r_reg.adc_clk;
   assign o_mux_sel_a  = r_reg.mux_a;
   assign o_mux_sel_b  = r_reg.mux_b;
   assign o_sample_a   = r_reg.sample_a;
   assign o_sample_b   = r_reg.sample_b;
   assign o_core_feed  = r_reg.feed;
   assign o_core_src_b = r_reg.src_b;
   assign o_cal_offset = r_reg.cal_offset;
   assign o_cal_gain   = r_reg.cal_gain;
   assign o_seq_busy   = (r_reg.state == ACS_ST_SEQ);
   assign o_conv_irq   = r_reg.irq;

endmodule

// >>> verif/acs_sequencer_chk.sv
// Port-level assertions for the conversion sequencer.
`timescale 1ns/1ps
module acs_sequencer_chk
   import acs_pkg::*;
(
   input wire logic       i_core_clk,
   input wire logic        i_nrst,
   input wire logic [7:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic       o_adc_clk,
   input wire logic [1:0] o_mux_sel_a,
   input wire logic [1:0] o_mux_sel_b,
   input wire logic       o_sample_a,
   input wire logic       o_sample_b,
   input wire logic       o_core_feed,
   input wire logic       o_core_src_b,
   input wire logic       o_cal_offset,
   input wire logic       o_cal_gain,
   input wire logic       o_seq_busy,
   input wire logic       o_conv_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_pair;
      o_sample_a && o_sample_b;
   endsequence
   sequence s_low2;
      !o_adc_clk ##1 !o_adc_clk;
   endsequence
   property p_adc_clk;
      $rose(o_adc_clk) |=> o_adc_clk ##1 s_low2 ##1 o_adc_clk;
   endproperty
   a_adc_clk: assert property (p_adc_clk)
      else $error("converter clock period is not four core clocks");
   property p_feed_gap;
      o_core_feed |=> !o_core_feed [*3];
   endproperty
   a_feed_gap: assert property (p_feed_gap)
      else $error("core fed off the converter clock");
   property p_pair_sel;
      s_pair |-> o_mux_sel_a == o_mux_sel_b;
   endproperty
   a_pair_sel: assert property (p_pair_sel)
      else $error("paired inputs do not match");
   property p_pair_next;
      (o_sample_a && o_sample_b && o_mux_sel_a != 2'h3) |-> ##8 s_pair
         ##0 (o_mux_sel_a == 2'($past(o_mux_sel_a, 8) + 2'h1));
   endproperty
   a_pair_next: assert property (p_pair_next)
      else $error("next pair not sampled two converter clocks later");
   property p_seq_next;
      (o_sample_a && !o_sample_b && o_seq_busy && o_mux_sel_a != 2'h3)
         |-> ##4 (o_sample_a
         && o_mux_sel_a == 2'($past(o_mux_sel_a, 4) + 2'h1));
   endproperty
   a_seq_next: assert property (p_seq_next)
      else $error("sequential samples not one converter clock apart");
   property p_bank_b;
      (o_sample_a && !o_sample_b && o_seq_busy && o_mux_sel_a == 2'h3)
         |-> ##4 (o_sample_b && o_mux_sel_b == 2'h0);
   endproperty
   a_bank_b: assert property (p_bank_b)
      else $error("input four not taken from the second bank");
   property p_irq;
      o_conv_irq |-> $past(o_core_feed, 15) && $past(o_core_src_b, 15);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not tied to the last feed");
   property p_cont;
      o_conv_irq |-> ##[0:8] (o_sample_a && o_mux_sel_a == 2'h0);
   endproperty
   a_cont: assert property (p_cont)
      else $error("no continuous conversion of input zero");
   property p_start;
      $rose(o_seq_busy) |-> ##[0:4] o_sample_a;
   endproperty
   a_start: assert property (p_start)
      else $error("first sample late after start");
   property p_cal;
      o_cal_offset |-> !o_cal_gain;
   endproperty
   a_cal: assert property (p_cal)
      else $error("both calibration routes on");
   property p_cal_mode;
      (i_wr && i_addr == ACS_OFF_CTRL) |=>
         (o_cal_offset == ($past(i_wdata[ACS_CTRL_MODE_LO+1:ACS_CTRL_MODE_LO])
                           == ACS_MODE_OFFCAL))
         && (o_cal_gain == ($past(i_wdata[ACS_CTRL_MODE_LO+1:ACS_CTRL_MODE_LO])
                            == ACS_MODE_GAINCAL));
   endproperty
   a_cal_mode: assert property (p_cal_mode)
      else $error("calibration routing does not follow the written mode");
endmodule
bind acs_sequencer acs_sequencer_chk chk_u (.i_core_clk(i_core_clk),
   .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .o_adc_clk(o_adc_clk), .o_mux_sel_a(o_mux_sel_a),
   .o_mux_sel_b(o_mux_sel_b), .o_sample_a(o_sample_a),
   .o_sample_b(o_sample_b), .o_core_feed(o_core_feed),
   .o_core_src_b(o_core_src_b), .o_cal_offset(o_cal_offset),
   .o_cal_gain(o_cal_gain), .o_seq_busy(o_seq_busy),
   .o_conv_irq(o_conv_irq));

// >>> verif/acs_core_model.sv
// Behavioural model of the hold amplifiers, inputs and pipelined core.
`timescale 1ns/1ps
module acs_core_model (
   // Clock
   input  wire logic        i_core_clk,
   // Control from the sequencer
   input  wire logic [1:0]  i_mux_sel_a,
   input  wire logic [1:0]  i_mux_sel_b,
   input  wire logic        i_sample_a,
   input  wire logic        i_sample_b,
   input  wire logic        i_core_feed,
   input  wire logic        i_core_src_b,
   // Input pattern chosen by the bench
   input  wire logic [11:0] i_base,
   // Core result
   output logic      [11:0] o_core_data,
   output logic             o_core_out_of_range
);
   logic [2:0]       held_a = 3'h0;
   logic [2:0]       held_b = 3'h4;
   logic [13:0]      pipe_v = '0;
   logic [13:0][2:0] pipe_c = '0;
   logic [11:0]      noise  = 12'h000;
   always @(posedge i_core_clk) begin
      noise <= noise + 12'h0f1;
      if (i_sample_a) held_a <= {1'b0, i_mux_sel_a};
      if (i_sample_b) held_b <= {1'b1, i_mux_sel_b};
      pipe_v <= {pipe_v[12:0], i_core_feed};
      pipe_c <= {pipe_c[12:0], i_core_src_b ? held_b : held_a};
   end
   // The bus wanders outside the result cycle, so a mistimed capture shows.
   assign o_core_data = pipe_v[13] ?
      (i_base ^ 12'(pipe_c[13] * 12'h111)) : noise;
   assign o_core_out_of_range = pipe_v[13] ? i_base[pipe_c[13]] : noise[0];
endmodule

// >>> verif/acs_sequencer_test.sv
// Self-checking testbench of the conversion sequencer.
`timescale 1ns/1ps
module acs_sequencer_test;
   import acs_pkg::*;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0, rd = 1'b0, pwm = 1'b0, pin = 1'b0;
   logic [11:0] base = 12'h000, core_data;
   logic [15:0] rng = 16'hd4c0, rdata;
   logic [1:0]  sel_a, sel_b;
   logic        oor, adc_clk, smp_a, smp_b, feed, src_b;
   logic        cal_off, cal_gain, busy, irq;
   int          errors = 0, comparisons = 0;
   int          cyc = 0;
   always #20 core_clk = ~core_clk;
   // Free-running count so start pulses keep a period that is a multiple of four.
   always @(posedge core_clk) cyc <= cyc + 1;
   acs_sequencer dut_u (.i_core_clk(core_clk), .i_nrst(nrst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_pwm_period_sync(pwm), .i_ext_start_pin(pin),
      .i_core_data(core_data), .i_core_out_of_range(oor),
      .o_adc_clk(adc_clk), .o_mux_sel_a(sel_a), .o_mux_sel_b(sel_b),
      .o_sample_a(smp_a), .o_sample_b(smp_b), .o_core_feed(feed),
      .o_core_src_b(src_b), .o_cal_offset(cal_off), .o_cal_gain(cal_gain),
      .o_seq_busy(busy), .o_conv_irq(irq));
   acs_core_model core_u (.i_core_clk(core_clk), .i_mux_sel_a(sel_a),
      .i_mux_sel_b(sel_b), .i_sample_a(smp_a), .i_sample_b(smp_b),
      .i_core_feed(feed), .i_core_src_b(src_b), .i_base(base),
      .o_core_data(core_data), .o_core_out_of_range(oor));
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [15:0] expv(input int ch);
      return {base ^ 12'(ch * 12'h111), 4'h0};
   endfunction
   task complete_run;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task reg_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      @(negedge core_clk);
      d = rdata;
   endtask
   task rd_chk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] v;
      reg_rd(a, v);
      check(v, exp);
   endtask
   task pulse(input logic ext);
      @(posedge core_clk);
      while (cyc % 4 != 0) @(posedge core_clk);
      if (ext) pin <= 1'b1;
      else pwm <= 1'b1;
      repeat (3) @(posedge core_clk);
      pin <= 1'b0;
      pwm <= 1'b0;
   endtask
   task run_seq(input int m);
      logic [15:0] v;
      logic        src;
      int          n;
      src = m[0];
      reg_wr(ACS_OFF_CTRL, 16'(m << ACS_CTRL_MODE_LO) | 16'(src));
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check(16'({cal_gain, cal_off}), 16'(m == 3 ? 2 : m == 2));
      pulse(!src);
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      check(16'(busy), 16'h0000);
      rng = lfsr(rng);
      base <= rng[11:0];
      pulse(src);
      repeat (6) @(posedge core_clk);
      reg_rd(ACS_OFF_STAT, v);
      check(16'(v[3:0]), 16'h0000);
      pulse(src);
      for (n = 0; n < 400; n++) begin
         @(negedge core_clk);
         if (irq === 1'b1) break;
      end
      check(16'(n < 400), 16'h0001);
      // A start taken while busy would already be running here.
      check(16'(busy), 16'h0000);
      for (n = 0; n < 8; n++) rd_chk(ACS_OFF_RES0 + 8'(n), expv(n));
      rd_chk(ACS_OFF_RANGE, {8'h00, base[7:0]});
      reg_rd(ACS_OFF_STAT, v);
      if (m != 1) check(16'(v[3:0]), 16'h000f);
      repeat (40) @(posedge core_clk);
      @(negedge core_clk);
      check(16'(busy), 16'h0000);
   endtask
   initial begin
      logic [15:0] v;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      rd_chk(ACS_OFF_CTRL, 16'h0000);
      rd_chk(8'h05, 16'h0000);
      for (int m = 0; m < 4; m++) run_seq(m);
      rng = lfsr(rng);
      base <= rng[11:0];
      repeat (40) @(posedge core_clk);
      rd_chk(ACS_OFF_XTRA, expv(0));
      reg_rd(ACS_OFF_STAT, v);
      check(16'(v[ACS_STAT_XOOR_BIT]), 16'(base[0]));
      complete_run();
   end
   // Four sequences need well under two thousand cycles.
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      complete_run();
   end
endmodule
